// ===== src/gnd_pkg.sv
// gnd_pkg: shared constants of the dual logic cell router.
// assumes the parameter command decoder delivers numeric ids and values.
package gnd_pkg;

  localparam int SRC_W = 4;
  localparam int PG_SRC_W = 5;
  localparam int ID_W = 4;
  localparam int VAL_W = 5;
  localparam int N_IN = 4;
  localparam int N_CODE = 16;

  // cell input selector codes
  localparam logic [SRC_W-1:0] CODE_LOW = 4'h0;
  localparam logic [SRC_W-1:0] CODE_HIGH = 4'h1;
  localparam logic [SRC_W-1:0] CODE_TRIG_WAIT = 4'h3;
  localparam logic [SRC_W-1:0] CODE_FRAME = 4'h4;
  localparam logic [SRC_W-1:0] CODE_EXPO = 4'h5;
  localparam logic [SRC_W-1:0] CODE_FVAL = 4'h6;
  localparam logic [SRC_W-1:0] CODE_LVAL = 4'h7;
  localparam logic [SRC_W-1:0] CODE_PGEN = 4'h8;
  localparam logic [SRC_W-1:0] CODE_USER0 = 4'hA;
  localparam logic [SRC_W-1:0] CODE_USER1 = 4'hB;
  localparam logic [SRC_W-1:0] CODE_TTL = 4'hC;
  localparam logic [SRC_W-1:0] CODE_LINK = 4'hD;
  localparam logic [SRC_W-1:0] CODE_CELL1 = 4'hE;
  localparam logic [SRC_W-1:0] CODE_CELL0 = 4'hF;

  // pulse generator clear source codes
  localparam logic [PG_SRC_W-1:0] PG_LOW = 5'h00;
  localparam logic [PG_SRC_W-1:0] PG_HIGH = 5'h01;
  localparam logic [PG_SRC_W-1:0] PG_TRIG_WAIT = 5'h04;
  localparam logic [PG_SRC_W-1:0] PG_FRAME = 5'h05;
  localparam logic [PG_SRC_W-1:0] PG_EXPO = 5'h06;
  localparam logic [PG_SRC_W-1:0] PG_FVAL = 5'h07;
  localparam logic [PG_SRC_W-1:0] PG_LVAL = 5'h08;
  localparam logic [PG_SRC_W-1:0] PG_USER0 = 5'h0A;
  localparam logic [PG_SRC_W-1:0] PG_USER1 = 5'h0B;
  localparam logic [PG_SRC_W-1:0] PG_TTL = 5'h0C;
  localparam logic [PG_SRC_W-1:0] PG_LINK = 5'h0D;
  localparam logic [PG_SRC_W-1:0] PG_CELL0 = 5'h0F;
  localparam logic [PG_SRC_W-1:0] PG_CELL1 = 5'h10;

  // parameter ids: 0..3 sources, 4..7 polarities, 8 clear source
  localparam logic [ID_W-1:0] ID_SRC_BASE = 4'h0;
  localparam logic [ID_W-1:0] ID_POL_BASE = 4'h4;
  localparam logic [ID_W-1:0] ID_PG_SRC = 4'h8;

  localparam logic [SRC_W-1:0] SRC_RST = 4'h0;
  localparam logic POL_RST = 1'b0;
  localparam logic [PG_SRC_W-1:0] PG_SRC_RST = 5'h00;
  localparam logic [VAL_W-1:0] POL_MAX = 5'h01;

endpackage

// ===== src/gnd_src_sel.sv
// gnd_src_sel: one cell input, code-indexed pick plus polarity.
// assumes the caller zeroes vector bits of codes this input does not offer.
`timescale 1ns/1ps
module gnd_src_sel
  import gnd_pkg::*;
(
  input wire logic [N_CODE-1:0] src_vec,
  input wire logic [SRC_W-1:0] sel,
  input wire logic inv,
  output logic level
);

  // unlisted codes have a zero bit in src_vec, so they read as low unless inv is set
  assign level = src_vec[sel] ^ inv;

endmodule

// ===== src/gnd_top.sv
// gnd_top: two configurable two-input logic cells with source routing.
// assumes all status inputs and command strobes are synchronous to mclk.
`timescale 1ns/1ps

// Functional notes
// - cell zero input one picks listed source codes
// - cell zero input two independent, resets low
// - cell one input one: code 15 cell zero
// - cell one input two independent, resets low
// - per input polarity: 0 pass, 1 invert
// - clear source codes 15, 16 pick cells
module gnd_top
  import gnd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic trigger_wait_flag,
  input wire logic frame_in_progress_flag,
  input wire logic exposure_in_progress_flag,
  input wire logic fval,
  input wire logic lval,
  input wire logic pulse_generator_zero_out,
  input wire logic user_level_zero,
  input wire logic user_level_one,
  input wire logic ttl_line_input,
  input wire logic link_control_input,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [ID_W-1:0] cmd_id,
  input wire logic [VAL_W-1:0] cmd_wdata,
  output logic rsp_valid_r,
  output logic rsp_err_r,
  output logic [VAL_W-1:0] rsp_rdata_r,
  output logic logic_cell_zero_out,
  output logic logic_cell_one_out,
  output logic pulse_gen_clear_source
);

  ////////////////////////////////////////////////////////////////////
  // settings
  logic [SRC_W-1:0] sel_r [N_IN];
  logic [N_IN-1:0] inv_r;
  logic [PG_SRC_W-1:0] pg_sel_r;
  logic cell0_r;
  logic cell1_r;
  logic [N_IN-1:0] in_lvl;
  logic [N_CODE-1:0] common_vec;
  logic [N_CODE-1:0] vec0;
  logic [N_CODE-1:0] vec1;
  logic id_src;
  logic id_pol;
  logic id_pg;
  logic [ID_W-1:0] pol_idx;
  logic cmd_ok;
  logic [VAL_W-1:0] rd_val;
  logic pg_nxt;

  assign id_src = cmd_id < ID_POL_BASE;
  assign id_pol = (cmd_id >= ID_POL_BASE) && (cmd_id < ID_PG_SRC);
  assign id_pg = cmd_id == ID_PG_SRC;
  assign pol_idx = cmd_id - ID_POL_BASE;

  // out of range source and polarity values are refused; any clear source value is taken, unlisted ones decode low
  always_comb begin
    cmd_ok = 1'b0;
    if (id_src) begin
      cmd_ok = cmd_wdata < VAL_W'(N_CODE);
    end else if (id_pol) begin
      cmd_ok = cmd_wdata <= POL_MAX;
    end else if (id_pg) begin
      cmd_ok = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < N_IN; i++) begin
        sel_r[i] <= SRC_RST;
      end
    end else if (cmd_wr && cmd_ok && id_src) begin
      sel_r[cmd_id[1:0]] <= cmd_wdata[SRC_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      inv_r <= {N_IN{POL_RST}};
    end else if (cmd_wr && cmd_ok && id_pol) begin
      inv_r[pol_idx[1:0]] <= cmd_wdata[0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_sel_r <= PG_SRC_RST;
    end else if (cmd_wr && cmd_ok && id_pg) begin
      pg_sel_r <= cmd_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command answers, one cycle after the strobe; write wins over read
  always_comb begin
    rd_val = '0;
    if (id_src) begin
      rd_val = VAL_W'(sel_r[cmd_id[1:0]]);
    end else if (id_pol) begin
      rd_val = VAL_W'(inv_r[pol_idx[1:0]]);
    end else if (id_pg) begin
      rd_val = pg_sel_r;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else begin
      rsp_valid_r <= cmd_wr || cmd_rd;
      if (cmd_wr) begin
        rsp_err_r <= !cmd_ok;
        rsp_rdata_r <= '0;
      end else if (cmd_rd) begin
        rsp_err_r <= !(id_src || id_pol || id_pg);
        rsp_rdata_r <= rd_val;
      end else begin
        rsp_err_r <= 1'b0;
        rsp_rdata_r <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // source vectors, bit index is the selector code
  always_comb begin
    common_vec = '0;
    common_vec[CODE_LOW] = 1'b0;
    common_vec[CODE_HIGH] = 1'b1;
    common_vec[CODE_TRIG_WAIT] = trigger_wait_flag;
    common_vec[CODE_FRAME] = frame_in_progress_flag;
    common_vec[CODE_EXPO] = exposure_in_progress_flag;
    common_vec[CODE_FVAL] = fval;
    common_vec[CODE_LVAL] = lval;
    common_vec[CODE_PGEN] = pulse_generator_zero_out;
    common_vec[CODE_USER0] = user_level_zero;
    common_vec[CODE_USER1] = user_level_one;
    common_vec[CODE_TTL] = ttl_line_input;
    common_vec[CODE_LINK] = link_control_input;
    vec0 = common_vec;
    vec0[CODE_CELL1] = cell1_r;
    vec1 = common_vec;
    vec1[CODE_CELL0] = cell0_r;
  end

  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      gnd_src_sel u_sel (
        .src_vec(g < 2 ? vec0 : vec1),
        .sel(sel_r[g]),
        .inv(inv_r[g]),
        .level(in_lvl[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // cells; the register breaks the cross-coupled loop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cell0_r <= 1'b1;
      cell1_r <= 1'b1;
    end else begin
      cell0_r <= !(in_lvl[0] && in_lvl[1]);
      cell1_r <= !(in_lvl[2] && in_lvl[3]);
    end
  end

  assign logic_cell_zero_out = cell0_r;
  assign logic_cell_one_out = cell1_r;

  always_comb begin
    pg_nxt = 1'b0;
    case (pg_sel_r)
      PG_HIGH: pg_nxt = 1'b1;
      PG_TRIG_WAIT: pg_nxt = trigger_wait_flag;
      PG_FRAME: pg_nxt = frame_in_progress_flag;
      PG_EXPO: pg_nxt = exposure_in_progress_flag;
      PG_FVAL: pg_nxt = fval;
      PG_LVAL: pg_nxt = lval;
      PG_USER0: pg_nxt = user_level_zero;
      PG_USER1: pg_nxt = user_level_one;
      PG_TTL: pg_nxt = ttl_line_input;
      PG_LINK: pg_nxt = link_control_input;
      PG_CELL0: pg_nxt = cell0_r;
      PG_CELL1: pg_nxt = cell1_r;
      default: pg_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_gen_clear_source <= 1'b0;
    end else begin
      pulse_gen_clear_source <= pg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  cell0_trig_a: assert property (
    sel_r[0] == CODE_TRIG_WAIT && sel_r[1] == CODE_HIGH && inv_r[1:0] == 2'h0
    |=> cell0_r == !$past(trigger_wait_flag))
    else $error("cell zero does not follow trigger wait");
  in2_low_a: assert property (
    sel_r[1] == CODE_LOW && !inv_r[1] |=> cell0_r)
    else $error("cell zero input two low must force high output");
  cell1_feed_a: assert property (
    sel_r[2] == CODE_CELL0 && sel_r[3] == CODE_HIGH && inv_r[3:2] == 2'h0
    |=> cell1_r == !$past(cell0_r))
    else $error("cell one does not follow cell zero");
  no_code14_a: assert property (
    sel_r[3] == CODE_CELL1 && !inv_r[3] |=> cell1_r)
    else $error("code 14 must read low on cell one");
  pol_inv_a: assert property (
    sel_r[0] == CODE_HIGH && inv_r[0] |=> cell0_r)
    else $error("inverted high input must give high output");
  pg_cell1_a: assert property (
    pg_sel_r == PG_CELL1 |=> pulse_gen_clear_source == $past(cell1_r))
    else $error("clear source does not follow cell one");
  nand_eq_a: assert property (
    1'b1 |=> cell1_r == !($past(in_lvl[2]) && $past(in_lvl[3])))
    else $error("cell one output is not the nand of its inputs");

  cell0_low_c: cover property (!cell0_r);
  chain_c: cover property (sel_r[2] == CODE_CELL0 && !cell1_r);
  pg_cell0_c: cover property (pg_sel_r == PG_CELL0 && pulse_gen_clear_source);

endmodule

// ===== testbench/gnd_top_test.sv
// gnd_top_test: command-driven bench for the dual logic cell router.
// assumes gnd_top answers one cycle after a command and registers outputs.
`timescale 1ns/1ps
module gnd_top_test;
  import gnd_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] st = 16'h0000;
  logic [ID_W-1:0] cmd_id = 4'h0;
  logic [VAL_W-1:0] cmd_wdata = 5'h00;
  logic rsp_valid_r, rsp_err_r, c0, c1, clr, lv;
  logic [VAL_W-1:0] rsp_rdata_r;
  int n_mismatch = 0;
  int samples_checked = 0;
  int b;

  always #10 mclk = ~mclk;

  // status bits sit at their own selector code positions
  gnd_top i_gnd_top (.mclk(mclk), .sys_rst(sys_rst),
    .trigger_wait_flag(st[3]), .frame_in_progress_flag(st[4]),
    .exposure_in_progress_flag(st[5]), .fval(st[6]), .lval(st[7]),
    .pulse_generator_zero_out(st[8]), .user_level_zero(st[10]),
    .user_level_one(st[11]), .ttl_line_input(st[12]),
    .link_control_input(st[13]), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_id(cmd_id), .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r),
    .rsp_err_r(rsp_err_r), .rsp_rdata_r(rsp_rdata_r),
    .logic_cell_zero_out(c0), .logic_cell_one_out(c1),
    .pulse_gen_clear_source(clr));

  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [5:0] g, input logic [5:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask

  task cmd(input logic w, input logic [ID_W-1:0] id,
    input logic [VAL_W-1:0] d, input logic e, input logic [VAL_W-1:0] q);
    int n;
    @(negedge mclk);
    cmd_wr = w;
    cmd_rd = !w;
    cmd_id = id;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    n = 0;
    while (rsp_valid_r !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (rsp_valid_r !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t no answer", $time);
      results;
    end else begin
      chk({rsp_err_r, rsp_rdata_r}, {e, q});
    end
  endtask

  task wr(input logic [ID_W-1:0] id, input logic [VAL_W-1:0] d);
    cmd(1'b1, id, d, 1'b0, 5'h00);
  endtask

  task rd(input logic [ID_W-1:0] id, input logic [VAL_W-1:0] q);
    cmd(1'b0, id, 5'h00, 1'b0, q);
  endtask

  // three edges cover the two-stage path through the feedback codes
  task look(input logic [2:0] x);
    repeat (3) @(negedge mclk);
    chk({3'h0, c0, c1, clr}, {3'h0, x});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    chk({3'h0, c0, c1, clr}, 6'h06);
    for (int i = 0; i < 9; i++) rd(4'(i), 5'h00);
    cmd(1'b1, 4'h9, 5'h01, 1'b1, 5'h00);
    cmd(1'b1, 4'h0, 5'h10, 1'b1, 5'h00);
    cmd(1'b1, 4'h4, 5'h02, 1'b1, 5'h00);
    cmd(1'b0, 4'h9, 5'h00, 1'b1, 5'h00);
    rd(4'h0, 5'h00);
    rd(4'h4, 5'h00);
    // each input in turn, the other input of its cell held high
    for (int k = 0; k < 4; k++) begin
      wr(4'(k ^ 1), 5'h01);
      for (int c = 0; c < 14; c++) begin
        wr(4'(k), 5'(c));
        for (int v = 0; v < 2; v++) begin
          st = v ? 16'h0001 << c : ~(16'h0001 << c);
          lv = (c == 1) ? 1'b1 : (c == 0 || c == 2 || c == 9) ? 1'b0 : v[0];
          look(k < 2 ? {~lv, 2'b10} : {1'b0, ~lv, 1'b0});
        end
      end
      wr(4'(k), 5'h01);
      wr(4'(k + 4), 5'h01);
      rd(4'(k + 4), 5'h01);
      look(k < 2 ? 3'b110 : 3'b010);
      wr(4'(k + 4), 5'h00);
    end
    // cross-coupled sources through the registered outputs
    wr(4'h2, 5'h0C);
    wr(4'h0, 5'h0E);
    for (int v = 0; v < 2; v++) begin
      st = v ? 16'h1000 : 16'h0000;
      look({v[0], ~v[0], 1'b0});
    end
    wr(4'h0, 5'h0C);
    wr(4'h2, 5'h0F);
    for (int v = 0; v < 2; v++) begin
      st = v ? 16'h1000 : 16'h0000;
      look({~v[0], v[0], 1'b0});
    end
    // opposite cell levels so each clear pick differs from its reset low
    st = 16'h0000;
    wr(4'h8, 5'h0F);
    look(3'b101);
    st = 16'h1000;
    wr(4'h8, 5'h10);
    look(3'b011);
    rd(4'h8, 5'h10);
    wr(4'h0, 5'h0F);
    wr(4'h2, 5'h0E);
    wr(4'h3, 5'h0E);
    look(3'b111);
    // clear source status codes, both cells parked high
    for (int p = 0; p < 15; p++) begin
      wr(4'h8, 5'(p));
      for (int v = 0; v < 2; v++) begin
        b = (p >= 4 && p <= 8) ? p - 1 : p;
        st = v ? 16'h0001 << b : ~(16'h0001 << b);
        lv = ((p >= 4 && p <= 8) || (p >= 10 && p <= 13)) ? v[0] : p == 1;
        look({2'b11, lv});
      end
    end
    results;
  end
endmodule
